// ### test/tb_timing_receiver_config_status.sv
// Self-checking bench for the receiver register set
`timescale 1ns/1ns
`default_nettype none
module tb_timing_receiver_config_status;
    logic clock, sys_rst, link_clock, reg_wr, reg_rd, cmd_valid, cmd_external, watchdog_timeout;
    logic frame_locked, shifters_ready, recovery_locked, low_freq_seen, freq_phase_done, watchdog_reset;
    logic [7:0] reg_addr, reg_wdata, payload_data_out, subaddress_out_bus, internal_cmd_data, internal_cmd_subaddress_out_bus;
    logic [23:0] reg_rdata, trigger_count, d, e;
    logic [13:0] cmd_id, chip_id;
    logic [15:0] cmd_payload;
    logic [11:0] crossing_count, c1;
    logic [2:0] shifter_loop_current, recovery_loop_current, test_mux_choice;
    logic [1:0] shifter_test_input;
    logic detector_test_enable_choice, link_input_choice, recovery_loop_test_reset, shifter_loop_test_reset;
    logic suppress_freq_boost, timeout_guard_off, stream_correction_on, test_pins_on;
    logic status_action, payload_out_strobe, internal_cmd_valid, mt, ex;
    logic [7:0] cfg[3];
    wire crossing_count_clear_cmd, trigger_accept, trigger_count_clear_cmd;
    int failures = 0, total_checks = 0, cycles = 0, seed = 32'h64e32d2f, n;
    trcs_top uut (.clock, .sys_rst, .link_clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .crossing_count_clear_cmd, .trigger_accept, .trigger_count_clear_cmd, .cmd_valid, .cmd_id, .chip_id,
        .cmd_external, .cmd_payload, .watchdog_timeout, .frame_locked, .shifters_ready, .recovery_locked,
        .low_freq_seen, .shifter_loop_current, .recovery_loop_current, .shifter_test_input, .test_mux_choice,
        .detector_test_enable_choice, .link_input_choice, .recovery_loop_test_reset, .shifter_loop_test_reset,
        .suppress_freq_boost, .timeout_guard_off, .stream_correction_on, .test_pins_on, .freq_phase_done,
        .watchdog_reset, .status_action, .payload_data_out, .subaddress_out_bus, .payload_out_strobe,
        .internal_cmd_valid, .internal_cmd_data, .internal_cmd_subaddress_out_bus, .crossing_count, .trigger_count);
    trcs_link_model model (.link_clock, .crossing_count_clear_cmd, .trigger_accept, .trigger_count_clear_cmd);
    always #5 clock = !clock;
    // Link clock free-runs at 125 ns, offset from the system clock
    initial begin
        link_clock = 1'b0;
        #7;
        forever begin
            #63 link_clock = 1'b1;
            #62 link_clock = 1'b0;
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Ceiling well above the longest phase, the 2048-cycle detection window
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Only the user fields move; the rest keep their init values
    function automatic logic [7:0] exp_cfg(input int i, input logic [7:0] v);
        logic [7:0] m;
        m = (i == 0) ? trcs_pkg::TRCS_LOOP_USER_MASK : trcs_pkg::TRCS_SCRUB_USER_MASK;
        return (v & m) | (trcs_pkg::TRCS_LOOP_DEFAULT & ~m & {8{i == 0}})
            | (trcs_pkg::TRCS_TEST_DEFAULT & ~m & {8{i == 1}}) | (trcs_pkg::TRCS_RECOV_DEFAULT & ~m & {8{i == 2}});
    endfunction
    initial begin
        {clock, reg_wr, reg_rd, cmd_valid, cmd_external, watchdog_timeout, low_freq_seen} = '0;
        {frame_locked, shifters_ready, recovery_locked} = 3'b111;
        {reg_addr, reg_wdata, cmd_id, cmd_payload} = '0;
        chip_id = 14'h1a5c;
        sys_rst = 1'b1;
        // Held past three link edges as well as the system cycles
        repeat (40) @(posedge clock);
        sys_rst <= 1'b0;
        n = 0;
        while (freq_phase_done !== 1'b1 && n < 2200) begin
            @(posedge clock);
            n++;
        end
        chk("freq_window", 1, n >= 2040 && n <= 2100);
        low_freq_seen <= 1'b1;
        repeat (2) @(posedge clock);
        low_freq_seen <= 1'b0;
        #1 chk("freq_restart", 0, freq_phase_done);
        for (int i = 0; i < 3; i++) begin
            rd(8'h13 + i[7:0]);
            chk("cfg_default", exp_cfg(i, 8'h00) | (i == 0 ? 8'h1a : 8'h80), d);
            repeat (3) begin
                cfg[i] = exp_cfg(i, 8'($random(seed)));
                wr(8'h13 + i[7:0], 8'($random(seed)) ^ cfg[i]);
                wr(8'h13 + i[7:0], cfg[i]);
                rd(8'h13 + i[7:0]);
                chk("cfg_rw", cfg[i], d);
            end
        end
        chk("cfg1_out", cfg[0], {shifter_test_input, recovery_loop_current, shifter_loop_current});
        chk("cfg2_out", cfg[1][6:0], {shifter_loop_test_reset, recovery_loop_test_reset, link_input_choice,
            detector_test_enable_choice, test_mux_choice});
        chk("cfg3_out", cfg[2][6:3], {test_pins_on, stream_correction_on, timeout_guard_off,
            suppress_freq_boost});
        repeat (4) begin
            {frame_locked, shifters_ready, recovery_locked} <= 3'($random(seed));
            repeat (6) @(posedge clock);
            rd(trcs_pkg::TRCS_ADDR_HEALTH);
            chk("status", {recovery_locked, shifters_ready, frame_locked, 5'h00}, d);
        end
        watchdog_timeout <= 1'b1;
        repeat (6) @(posedge clock);
        watchdog_timeout <= 1'b0;
        rd(trcs_pkg::TRCS_ADDR_HEALTH);
        chk("wd_flag", 1, d[4]);
        chk("wd_out", 1, watchdog_reset);
        e = d;
        wr(trcs_pkg::TRCS_ADDR_HEALTH, 8'h0f);
        chk("status_action", 1, status_action);
        rd(trcs_pkg::TRCS_ADDR_HEALTH);
        chk("status_kept", e, d);
        repeat (12) begin
            mt = ($random(seed) % 4) != 0;
            ex = 1'($random(seed));
            @(posedge clock);
            cmd_valid <= 1'b1;
            cmd_external <= ex;
            cmd_payload <= 16'($random(seed));
            cmd_id <= mt ? chip_id : chip_id ^ (14'h0001 << ($unsigned($random(seed)) % 14));
            @(posedge clock);
            cmd_valid <= 1'b0;
            #1;
            chk("ext_strobe", mt & ex, payload_out_strobe);
            chk("int_valid", mt & !ex, internal_cmd_valid);
            if (mt && ex) chk("ext_bus", cmd_payload, {subaddress_out_bus, payload_data_out});
            if (mt && !ex) chk("int_bus", cmd_payload, {internal_cmd_subaddress_out_bus, internal_cmd_data});
        end
        n = 5 + ($unsigned($random(seed)) % 20);
        model.send_trig(n);
        repeat (12) @(posedge clock);
        rd(trcs_pkg::TRCS_ADDR_TRIG);
        chk("tally", n, d);
        chk("tally_out", n, trigger_count);
        wr(trcs_pkg::TRCS_ADDR_TRIG, 8'h00);
        rd(trcs_pkg::TRCS_ADDR_TRIG);
        chk("tally_wclr", 0, d);
        model.send_trig(3);
        model.send_clear(1'b1);
        repeat (12) @(posedge clock);
        rd(trcs_pkg::TRCS_ADDR_TRIG);
        chk("tally_bclr", 0, d);
        @(posedge link_clock) #1 c1 = crossing_count;
        repeat (10) @(posedge link_clock);
        #1 chk("cross_step", 12'(c1 + 10), crossing_count);
        model.send_clear(1'b0);
        #1 chk("cross_bclr", 0, crossing_count);
        repeat (20) @(posedge link_clock);
        wr(trcs_pkg::TRCS_ADDR_CROSS, 8'h00);
        repeat (60) @(posedge clock);
        chk("cross_wclr", 1, crossing_count < 8);
        stop_test();
    end
endmodule
`default_nettype wire

// ### test/trcs_link_model.sv
// Link-side model driving trigger accepts and broadcast clears
`timescale 1ns/1ns
`default_nettype none
module trcs_link_model (
    input wire logic link_clock,
    output logic crossing_count_clear_cmd,
    output logic trigger_accept,
    output logic trigger_count_clear_cmd
);
    initial begin
        crossing_count_clear_cmd = 1'b0;
        trigger_accept = 1'b0;
        trigger_count_clear_cmd = 1'b0;
    end
    // accepts spaced one idle link cycle apart
    task automatic send_trig(input int n);
        repeat (n) begin
            @(posedge link_clock);
            trigger_accept <= 1'b1;
            @(posedge link_clock);
            trigger_accept <= 1'b0;
        end
    endtask
    // broadcast clears last one link cycle
    task automatic send_clear(input logic trig);
        @(posedge link_clock);
        crossing_count_clear_cmd <= !trig;
        trigger_count_clear_cmd <= trig;
        @(posedge link_clock);
        crossing_count_clear_cmd <= 1'b0;
        trigger_count_clear_cmd <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verilog/trcs_link.sv
// Link-clock logic: crossing counter and toggle crossings of link events
`timescale 1ns/1ns
`default_nettype none
module trcs_link (
    input wire logic link_clock,
    input wire logic link_rst,
    input wire logic crossing_count_clear_cmd,
    input wire logic trigger_accept,
    input wire logic trigger_count_clear_cmd,
    output logic [11:0] crossing_count,
    trcs_sync_if.link sif
);
    logic [11:0] cross_reg, cross_next;
    logic inc_tog_reg, inc_tog_next, clr_tog_reg, clr_tog_next;
    logic wclr_s1_reg, wclr_s2_reg, wclr_s3_reg;
    logic init_s1_reg, init_s2_reg;

    always_comb begin
        cross_next = cross_reg + 12'h0001;
        if (crossing_count_clear_cmd || (wclr_s2_reg != wclr_s3_reg) || init_s2_reg) begin
            cross_next = 12'h0000;
        end
        inc_tog_next = inc_tog_reg ^ trigger_accept;
        clr_tog_next = clr_tog_reg ^ trigger_count_clear_cmd;
        // Known start level, else the toggles stay unknown and never count
        if (init_s2_reg) begin
            inc_tog_next = 1'b0;
            clr_tog_next = 1'b0;
        end
    end

    always_ff @(posedge link_clock) begin
        init_s1_reg <= link_rst;
        init_s2_reg <= init_s1_reg;
        wclr_s1_reg <= sif.cross_wr_clear;
        wclr_s2_reg <= wclr_s1_reg;
        wclr_s3_reg <= wclr_s2_reg;
        cross_reg <= cross_next;
        inc_tog_reg <= inc_tog_next;
        clr_tog_reg <= clr_tog_next;
    end

    assign crossing_count = cross_reg;
    assign sif.cross_clear = init_s2_reg;
    assign sif.trig_inc = inc_tog_reg;
    assign sif.trig_clear = clr_tog_reg;

    cross_step_a: assert property (@(posedge link_clock)
        !crossing_count_clear_cmd && !init_s2_reg && (wclr_s2_reg == wclr_s3_reg)
        |=> cross_reg == $past(cross_reg) + 12'h0001)
        else $error("crossing counter did not step");
    cross_clear_a: assert property (@(posedge link_clock) crossing_count_clear_cmd |=> cross_reg == 12'h0000)
        else $error("crossing counter not cleared");
endmodule
`default_nettype wire

// ### verilog/trcs_pkg.sv
// Package with register map, field positions, defaults and timing counts
package trcs_pkg;
    localparam logic [7:0] TRCS_ADDR_LOOP = 8'h0013;
    localparam logic [7:0] TRCS_ADDR_TEST = 8'h0014;
    localparam logic [7:0] TRCS_ADDR_RECOV = 8'h0015;
    localparam logic [7:0] TRCS_ADDR_HEALTH = 8'h0016;
    localparam logic [7:0] TRCS_ADDR_CROSS = 8'h0017;
    localparam logic [7:0] TRCS_ADDR_TRIG = 8'h0018;
    localparam logic [7:0] TRCS_LOOP_DEFAULT = 8'h001a;
    localparam logic [7:0] TRCS_TEST_DEFAULT = 8'h0095;
    localparam logic [7:0] TRCS_RECOV_DEFAULT = 8'h00a7;
    localparam logic [7:0] TRCS_LOOP_USER_MASK = 8'h003f;
    localparam logic [7:0] TRCS_SCRUB_USER_MASK = 8'h0080;
    localparam int TRCS_BIT_SCRUB = 7;
    localparam int TRCS_BIT_LINKSEL = 4;
    localparam int TRCS_BIT_PLLRST = 5;
    localparam int TRCS_BIT_DLLRST = 6;
    localparam int TRCS_BIT_PDSEL = 3;
    localparam int TRCS_BIT_BOOST = 3;
    localparam int TRCS_BIT_GUARD = 4;
    localparam int TRCS_BIT_HAMM = 5;
    localparam int TRCS_BIT_TESTIO = 6;
    localparam int TRCS_CROSS_W = 12;
    localparam int TRCS_TRIG_W = 24;
    localparam int TRCS_FREQ_BASE = 4;
    localparam logic [3:0] TRCS_SCRUB_LAST = 4'h0002;
endpackage

// ### verilog/trcs_sync_if.sv
// Interface carrying link-domain events into the system domain
`timescale 1ns/1ns
`default_nettype none
interface trcs_sync_if;
    logic cross_clear;
    logic trig_inc;
    logic trig_clear;
    logic cross_wr_clear;
    modport link (input cross_wr_clear, output cross_clear, output trig_inc, output trig_clear);
    modport sys (output cross_wr_clear, input cross_clear, input trig_inc, input trig_clear);
endinterface
`default_nettype wire

// ### verilog/trcs_top.sv
// Configuration, counter and status register set of the timing receiver
`timescale 1ns/1ns
`default_nettype none
module trcs_top (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic link_clock,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [23:0] reg_rdata,
    input wire logic crossing_count_clear_cmd,
    input wire logic trigger_accept,
    input wire logic trigger_count_clear_cmd,
    input wire logic cmd_valid,
    input wire logic [13:0] cmd_id,
    input wire logic [13:0] chip_id,
    input wire logic cmd_external,
    input wire logic [15:0] cmd_payload,
    input wire logic watchdog_timeout,
    input wire logic frame_locked,
    input wire logic shifters_ready,
    input wire logic recovery_locked,
    input wire logic low_freq_seen,
    output logic [2:0] shifter_loop_current,
    output logic [2:0] recovery_loop_current,
    output logic [1:0] shifter_test_input,
    output logic [2:0] test_mux_choice,
    output logic detector_test_enable_choice,
    output logic link_input_choice,
    output logic recovery_loop_test_reset,
    output logic shifter_loop_test_reset,
    output logic suppress_freq_boost,
    output logic timeout_guard_off,
    output logic stream_correction_on,
    output logic test_pins_on,
    output logic freq_phase_done,
    output logic watchdog_reset,
    output logic status_action,
    output logic [7:0] payload_data_out,
    output logic [7:0] subaddress_out_bus,
    output logic payload_out_strobe,
    output logic internal_cmd_valid,
    output logic [7:0] internal_cmd_data,
    output logic [7:0] internal_cmd_subaddress_out_bus,
    output logic [11:0] crossing_count,
    output logic [23:0] trigger_count
);
    typedef enum logic [1:0] {
        TRCS_SCRUB_IDLE = 2'b00,
        TRCS_SCRUB_CHECK = 2'b01,
        TRCS_SCRUB_FIX = 2'b10
    } trcs_scrub_t;

    trcs_sync_if sif ();

    logic [7:0] loop_reg, loop_next, test_reg, test_next, recov_reg, recov_next;
    logic [7:0] shadow_reg [0:2];
    logic [7:0] shadow_next [0:2];
    trcs_scrub_t scrub_reg, scrub_next;
    logic [3:0] scan_reg, scan_next;
    logic [23:0] trig_reg, trig_next;
    logic [1:0] inc_s_reg, clr_s_reg;
    logic inc_d_reg, clr_d_reg, init_s1_reg, init_s2_reg;
    logic wclr_tog_reg, wclr_tog_next;
    logic auto_flag_reg, auto_flag_next;
    logic [3:0] st_s1_reg, st_s2_reg;
    logic [127:0] freq_cnt_reg, freq_cnt_next;
    logic freq_done_reg, freq_done_next;
    logic [7:0] pdata_reg, pdata_next, psub_reg, psub_next;
    logic pstb_reg, pstb_next;
    logic icv_reg, icv_next;
    logic [7:0] icd_reg, icd_next, ics_reg, ics_next;
    logic [23:0] rdata_reg, rdata_next;
    logic act_reg, act_next;
    logic scrub_on;
    logic [7:0] health;

    // Registers protected by the scrubber, selected by scan index
    function automatic logic [7:0] trcs_cfg_pick(input logic [3:0] idx, input logic [7:0] a,
                                                 input logic [7:0] b, input logic [7:0] c);
        case (idx)
            4'h0000: trcs_cfg_pick = a;
            4'h0001: trcs_cfg_pick = b;
            default: trcs_cfg_pick = c;
        endcase
    endfunction

    trcs_link link_u (
        .link_clock(link_clock),
        .link_rst(sys_rst),
        .crossing_count_clear_cmd(crossing_count_clear_cmd),
        .trigger_accept(trigger_accept),
        .trigger_count_clear_cmd(trigger_count_clear_cmd),
        .crossing_count(crossing_count),
        .sif(sif.link)
    );

    // either redundant enable keeps scrubber on
    assign scrub_on = test_reg[trcs_pkg::TRCS_BIT_SCRUB] || recov_reg[trcs_pkg::TRCS_BIT_SCRUB];

    always_comb begin
        loop_next = loop_reg;
        test_next = test_reg;
        recov_next = recov_reg;
        for (int i = 0; i < 3; i++) begin
            shadow_next[i] = shadow_reg[i];
        end
        scrub_next = scrub_reg;
        scan_next = scan_reg;
        // scrubber restores an upset register from its copy
        case (scrub_reg)
            TRCS_SCRUB_IDLE: begin
                if (scrub_on) begin
                    scrub_next = TRCS_SCRUB_CHECK;
                end
            end
            TRCS_SCRUB_CHECK: begin
                if (trcs_cfg_pick(scan_reg, loop_reg, test_reg, recov_reg) !=
                    shadow_reg[scan_reg[1:0]]) begin
                    scrub_next = TRCS_SCRUB_FIX;
                end else begin
                    scan_next = (scan_reg == trcs_pkg::TRCS_SCRUB_LAST) ? 4'h0000 : scan_reg + 4'h0001;
                    scrub_next = scrub_on ? TRCS_SCRUB_CHECK : TRCS_SCRUB_IDLE;
                end
            end
            TRCS_SCRUB_FIX: begin
                case (scan_reg)
                    4'h0000: loop_next = shadow_reg[0];
                    4'h0001: test_next = shadow_reg[1];
                    default: recov_next = shadow_reg[2];
                endcase
                scrub_next = TRCS_SCRUB_CHECK;
            end
            default: scrub_next = TRCS_SCRUB_IDLE;
        endcase
        // loop currents writable, test selects held
        if (reg_wr && reg_addr == trcs_pkg::TRCS_ADDR_LOOP) begin
            loop_next = (reg_wdata & trcs_pkg::TRCS_LOOP_USER_MASK) |
                        (trcs_pkg::TRCS_LOOP_DEFAULT & ~trcs_pkg::TRCS_LOOP_USER_MASK);
            shadow_next[0] = loop_next;
        end
        // only scrubber enable is user-changeable here
        if (reg_wr && reg_addr == trcs_pkg::TRCS_ADDR_TEST) begin
            test_next = (reg_wdata & trcs_pkg::TRCS_SCRUB_USER_MASK) |
                        (trcs_pkg::TRCS_TEST_DEFAULT & ~trcs_pkg::TRCS_SCRUB_USER_MASK);
            shadow_next[1] = test_next;
        end
        // recovery fields fixed, scrubber enable writable
        if (reg_wr && reg_addr == trcs_pkg::TRCS_ADDR_RECOV) begin
            recov_next = (reg_wdata & trcs_pkg::TRCS_SCRUB_USER_MASK) |
                         (trcs_pkg::TRCS_RECOV_DEFAULT & ~trcs_pkg::TRCS_SCRUB_USER_MASK);
            shadow_next[2] = recov_next;
        end
        if (sys_rst) begin
            loop_next = trcs_pkg::TRCS_LOOP_DEFAULT;
            test_next = trcs_pkg::TRCS_TEST_DEFAULT;
            recov_next = trcs_pkg::TRCS_RECOV_DEFAULT;
            shadow_next[0] = trcs_pkg::TRCS_LOOP_DEFAULT;
            shadow_next[1] = trcs_pkg::TRCS_TEST_DEFAULT;
            shadow_next[2] = trcs_pkg::TRCS_RECOV_DEFAULT;
            scrub_next = TRCS_SCRUB_IDLE;
            scan_next = 4'h0000;
        end
    end

    always_ff @(posedge clock) begin
        loop_reg <= loop_next;
        test_reg <= test_next;
        recov_reg <= recov_next;
        for (int i = 0; i < 3; i++) begin
            shadow_reg[i] <= shadow_next[i];
        end
        scrub_reg <= scrub_next;
        scan_reg <= scan_next;
    end

    // Link toggles and status pins are synchronised before use
    always_ff @(posedge clock) begin
        inc_s_reg <= {inc_s_reg[0], sif.trig_inc};
        clr_s_reg <= {clr_s_reg[0], sif.trig_clear};
        inc_d_reg <= inc_s_reg[1];
        clr_d_reg <= clr_s_reg[1];
        init_s1_reg <= sif.cross_clear;
        init_s2_reg <= init_s1_reg;
        st_s1_reg <= {recovery_locked, shifters_ready, frame_locked, watchdog_timeout};
        st_s2_reg <= st_s1_reg;
    end

    assign health = {st_s2_reg[3], st_s2_reg[2], st_s2_reg[1], auto_flag_reg, 4'h0000};

    always_comb begin
        trig_next = trig_reg;
        // tally steps on trigger, clears on command, write or init
        if (inc_s_reg[1] != inc_d_reg) begin
            trig_next = trig_reg + 24'h0000_0001;
        end
        if ((clr_s_reg[1] != clr_d_reg) || (reg_wr && reg_addr == trcs_pkg::TRCS_ADDR_TRIG) || sys_rst) begin
            trig_next = 24'h0000_0000;
        end
        // a register write clears the crossing counter
        wclr_tog_next = wclr_tog_reg ^ (reg_wr && reg_addr == trcs_pkg::TRCS_ADDR_CROSS);
        // watchdog flag is sticky; disabled guard never sets it
        auto_flag_next = auto_flag_reg;
        if (st_s2_reg[0] && !recov_reg[trcs_pkg::TRCS_BIT_GUARD]) begin
            auto_flag_next = 1'b1;
        end
        if (sys_rst) begin
            auto_flag_next = 1'b0;
        end
        // count until 2^(n+4) cycles without low frequency
        freq_cnt_next = freq_cnt_reg;
        freq_done_next = freq_done_reg;
        if (low_freq_seen) begin
            freq_cnt_next = '0;
            freq_done_next = 1'b0;
        end else if (!freq_done_reg) begin
            freq_cnt_next = freq_cnt_reg + 128'd1;
            if (freq_cnt_next[recov_reg[2:0] + trcs_pkg::TRCS_FREQ_BASE]) begin
                freq_done_next = 1'b1;
            end
        end
        if (sys_rst) begin
            freq_cnt_next = '0;
            freq_done_next = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        trig_reg <= trig_next;
        wclr_tog_reg <= sys_rst ? 1'b0 : wclr_tog_next;
        auto_flag_reg <= auto_flag_next;
        freq_cnt_reg <= freq_cnt_next;
        freq_done_reg <= freq_done_next;
    end

    assign sif.cross_wr_clear = wclr_tog_reg;

    always_comb begin
        pdata_next = pdata_reg;
        psub_next = psub_reg;
        pstb_next = 1'b0;
        icv_next = 1'b0;
        icd_next = icd_reg;
        ics_next = ics_reg;
        act_next = 1'b0;
        rdata_next = rdata_reg;
        // accept on id match, route by selector
        if (cmd_valid && cmd_id == chip_id) begin
            if (cmd_external) begin
                pdata_next = cmd_payload[7:0];
                psub_next = cmd_payload[15:8];
                pstb_next = 1'b1;
            end else begin
                icv_next = 1'b1;
                icd_next = cmd_payload[7:0];
                ics_next = cmd_payload[15:8];
            end
        end
        // status write raises action pulse only
        if (reg_wr && reg_addr == trcs_pkg::TRCS_ADDR_HEALTH) begin
            act_next = 1'b1;
        end
        if (reg_rd) begin
            case (reg_addr)
                trcs_pkg::TRCS_ADDR_LOOP: rdata_next = {16'h0000, loop_reg};
                trcs_pkg::TRCS_ADDR_TEST: rdata_next = {16'h0000, test_reg};
                trcs_pkg::TRCS_ADDR_RECOV: rdata_next = {16'h0000, recov_reg};
                trcs_pkg::TRCS_ADDR_HEALTH: rdata_next = {16'h0000, health};
                trcs_pkg::TRCS_ADDR_TRIG: rdata_next = trig_reg;
                default: rdata_next = 24'h0000_0000;
            endcase
        end
        if (sys_rst) begin
            pdata_next = 8'h0000;
            psub_next = 8'h0000;
            icd_next = 8'h0000;
            ics_next = 8'h0000;
            rdata_next = 24'h0000_0000;
            pstb_next = 1'b0;
            icv_next = 1'b0;
            act_next = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        pdata_reg <= pdata_next;
        psub_reg <= psub_next;
        pstb_reg <= pstb_next;
        icv_reg <= icv_next;
        icd_reg <= icd_next;
        ics_reg <= ics_next;
        act_reg <= act_next;
        rdata_reg <= rdata_next;
    end

    assign shifter_loop_current = loop_reg[2:0];
    assign recovery_loop_current = loop_reg[5:3];
    assign shifter_test_input = loop_reg[7:6];
    assign test_mux_choice = test_reg[2:0];
    assign detector_test_enable_choice = test_reg[trcs_pkg::TRCS_BIT_PDSEL];
    assign link_input_choice = test_reg[trcs_pkg::TRCS_BIT_LINKSEL];
    assign recovery_loop_test_reset = test_reg[trcs_pkg::TRCS_BIT_PLLRST];
    assign shifter_loop_test_reset = test_reg[trcs_pkg::TRCS_BIT_DLLRST];
    assign suppress_freq_boost = recov_reg[trcs_pkg::TRCS_BIT_BOOST];
    assign timeout_guard_off = recov_reg[trcs_pkg::TRCS_BIT_GUARD];
    assign stream_correction_on = recov_reg[trcs_pkg::TRCS_BIT_HAMM];
    assign test_pins_on = recov_reg[trcs_pkg::TRCS_BIT_TESTIO];
    assign freq_phase_done = freq_done_reg;
    assign watchdog_reset = auto_flag_reg;
    assign status_action = act_reg;
    assign payload_data_out = pdata_reg;
    assign subaddress_out_bus = psub_reg;
    assign payload_out_strobe = pstb_reg;
    assign internal_cmd_valid = icv_reg;
    assign internal_cmd_data = icd_reg;
    assign internal_cmd_subaddress_out_bus = ics_reg;
    assign trigger_count = trig_reg;
    assign reg_rdata = rdata_reg;

    sequence ext_cmd_s;
        cmd_valid && cmd_id == chip_id && cmd_external;
    endsequence

    // external command gives one strobe with payload
    ext_strobe_a: assert property (@(posedge clock) disable iff (sys_rst)
        ext_cmd_s |=> pstb_reg && psub_reg == $past(cmd_payload[15:8]) && pdata_reg == $past(cmd_payload[7:0]))
        else $error("external payload not presented");
    id_filter_a: assert property (@(posedge clock) disable iff (sys_rst)
        cmd_id != chip_id |=> !pstb_reg && !icv_reg)
        else $error("foreign command accepted");
    int_route_a: assert property (@(posedge clock) disable iff (sys_rst)
        cmd_valid && cmd_id == chip_id && !cmd_external |=> icv_reg && !pstb_reg)
        else $error("internal command misrouted");
    status_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == trcs_pkg::TRCS_ADDR_HEALTH |=> act_reg && $stable(auto_flag_reg))
        else $error("status write misbehaved");
    status_low_a: assert property (@(posedge clock) health[3:0] == 4'h0000)
        else $error("status low bits not zero");
    init_default_a: assert property (@(posedge clock) sys_rst |=> loop_reg == trcs_pkg::TRCS_LOOP_DEFAULT &&
        test_reg == trcs_pkg::TRCS_TEST_DEFAULT && recov_reg == trcs_pkg::TRCS_RECOV_DEFAULT)
        else $error("defaults not loaded");
    // test mux field unaffected by writes
    mux_fixed_a: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == trcs_pkg::TRCS_ADDR_TEST && scrub_reg != TRCS_SCRUB_FIX |=> test_reg[2:0] == 3'h5)
        else $error("test mux changed");
    flag_sticky_a: assert property (@(posedge clock) disable iff (sys_rst)
        auto_flag_reg |=> auto_flag_reg)
        else $error("watchdog flag dropped");
endmodule
`default_nettype wire
